// ==== dv/sd_adc_core_asserts.sv ====
// pin-level assertions for the converter core
// assumes it is bound into sd_adc_core and sees only its ports
`timescale 1ns/1ns
`default_nettype none
module sd_adc_core_chk #(parameter BASE_CYCLES = 4) (
   input wire logic        clock_in, rst_in, oscillator_source_select_in, rc_osc_in,
   input wire logic        source_clock_pin_out, source_clock_pin_oe_n_out, rc_osc_enable_out,
   input wire logic        chip_select_n_in, serial_clock_in, serial_data_out,
   input wire logic        serial_data_oe_n_out, busy_n_out,
   input wire logic [14:0] control_out
);
   default clocking @(posedge clock_in); endclocking
   default disable iff (rst_in);
   sequence s_abort;
      !busy_n_out ##0 $fell(chip_select_n_in);
   endsequence
   chk_osc_drive: assert property (
      source_clock_pin_oe_n_out == !oscillator_source_select_in) else $error("clock pin drive");
   chk_osc_copy: assert property (
      rc_osc_enable_out |-> source_clock_pin_out == rc_osc_in) else $error("clock pin level");
   chk_osc_off: assert property (
      !oscillator_source_select_in |-> !rc_osc_enable_out) else $error("oscillator left on");
   chk_dout_release: assert property (
      chip_select_n_in[*5] |-> serial_data_oe_n_out) else $error("data out not released");
   chk_dout_fall: assert property (
      $changed(serial_data_out) && !serial_data_oe_n_out |-> !serial_clock_in)
      else $error("data out moved while serial clock high");
   chk_start_cs: assert property (
      $fell(busy_n_out) |-> chip_select_n_in) else $error("start without select rise");
   chk_ctrl_cs: assert property (
      !$stable(control_out) |-> $past(chip_select_n_in, 2)) else $error("control moved");
   chk_busy_abort: assert property (
      s_abort |-> ##[1:8] busy_n_out) else $error("abort did not stop conversion");
endmodule
bind sd_adc_core sd_adc_core_chk #(.BASE_CYCLES(BASE_CYCLES)) chk (
   .clock_in                    (clock_in),
   .rst_in                      (rst_in),
   .oscillator_source_select_in (oscillator_source_select_in),
   .rc_osc_in                   (rc_osc_in),
   .source_clock_pin_out        (source_clock_pin_out),
   .source_clock_pin_oe_n_out   (source_clock_pin_oe_n_out),
   .rc_osc_enable_out           (rc_osc_enable_out),
   .chip_select_n_in            (chip_select_n_in),
   .serial_clock_in             (serial_clock_in),
   .serial_data_out             (serial_data_out),
   .serial_data_oe_n_out        (serial_data_oe_n_out),
   .busy_n_out                  (busy_n_out),
   .control_out                 (control_out)
);
`default_nettype wire

// ==== dv/serial_ctrl_model.sv ====
// serial bus controller model: mode 0, msb first, gap between the two bytes
// assumes its caller starts each transfer just after a falling clock_in edge
`timescale 1ns/1ns
`default_nettype none
module serial_ctrl_model (
   input  wire logic clock_in,
   input  wire logic dout_in,
   output var  logic cs_n_out = 1'b1,
   output var  logic sclk_out = 1'b0,
   output var  logic din_out = 1'b0
);
   // 32 cycles high and 64 cycles low keep the serial clock under 2 mhz
   task automatic tick(input int n);
      repeat (n) @(negedge clock_in);
   endtask
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      cs_n_out = 1'b0;
      for (int i = 15; i >= 0; i--) begin
         tick(32);
         din_out = w[i];
         tick(32);
         sclk_out = 1'b1;
         r[i] = dout_in;
         tick(32);
         sclk_out = 1'b0;
         if (i == 8) tick(150);
      end
      tick(32);
      cs_n_out = 1'b1;
      din_out = ~din_out;
   endtask
endmodule
`default_nettype wire

// ==== dv/sigma_delta_adc_serial_control_test.sv ====
// self-checking bench for the converter core
// assumes the serial controller model drives the serial pins
`timescale 1ns/1ns
`default_nettype none
module sigma_delta_adc_serial_control_test;
   logic        clock_in = 0, rst_in = 1, sel = 0, src = 0, rc = 0, comp = 1, ovr = 1;
   wire logic   cs_n, sclk, din, dout, oe_n, busy_n, pin_out, pin_oe_n, rc_en;
   wire logic   [14:0] ctrl;
   // the clock pin is two-way: the device owns it in oscillator mode
   wire logic   pin = pin_oe_n ? src : pin_out;
   int          fails = 0, cmp_count = 0;
   logic [15:0] r;
   always #4 clock_in = ~clock_in;
   always #24 src = ~src;
   always #40 rc = ~rc;
   sd_adc_core #(.BASE_CYCLES(4)) uut (.clock_in(clock_in), .rst_in(rst_in),
      .oscillator_source_select_in(sel), .source_clock_pin_in(pin), .rc_osc_in(rc),
      .source_clock_pin_out(pin_out), .source_clock_pin_oe_n_out(pin_oe_n),
      .rc_osc_enable_out(rc_en), .comparator_in(comp), .overrange_detect_in(ovr),
      .chip_select_n_in(cs_n), .serial_clock_in(sclk), .serial_data_in(din),
      .serial_data_out(dout), .serial_data_oe_n_out(oe_n), .busy_n_out(busy_n),
      .control_out(ctrl));
   serial_ctrl_model host (.clock_in(clock_in), .dout_in(dout), .cs_n_out(cs_n),
      .sclk_out(sclk), .din_out(din));
   task automatic check(input string n, input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s expected %h seen %h", n, exp, seen);
      end
   endtask
   task automatic settle;
      repeat (10) @(negedge clock_in);
   endtask
   task automatic wait_idle;
      for (int i = 0; i < 9000 && busy_n !== 1'b1; i++) @(negedge clock_in);
   endtask
   task automatic report_and_stop;
      $display("compares %0d mismatches %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (40000) @(posedge clock_in);
      fails++;
      report_and_stop;
   end
   initial begin
      repeat (20) @(negedge clock_in);
      rst_in = 0;
      check("idle", 16'({busy_n, oe_n}), 16'h0003);
      host.xfer(16'h7fff, r);
      check("first word", r, 16'h0000);
      settle;
      check("ctrl", 16'({busy_n, ctrl}), 16'h8000);
      $display("test reset done");
      host.xfer(16'h8000, r);
      settle;
      check("busy", 16'(busy_n), 16'h0000);
      wait_idle;
      comp = 0;
      ovr = 0;
      host.xfer(16'h8080, r);
      check("sign over", 16'(r[15:14]), 16'h0001);
      settle;
      check("ctrl", 16'(ctrl), 16'h0080);
      wait_idle;
      host.xfer(16'h0000, r);
      check("down count", 16'(r[15:14]), 16'h0002);
      $display("test convert done");
      sel = 1;
      host.xfer(16'h9f00, r);
      settle;
      check("rc mode", 16'({rc_en, pin_oe_n, busy_n}), 16'h0004);
      // a second frame during the conversion must stop it
      host.xfer(16'h0000, r);
      check("abort", 16'({busy_n, ctrl}), 16'h9f00);
      sel = 0;
      settle;
      check("ext mode", 16'({rc_en, pin_oe_n}), 16'h0001);
      $display("test clock source done");
      report_and_stop;
   end
endmodule
`default_nettype wire

// ==== rtl/osc_clock_divider.v ====
// oversampling tick generator: picks the source clock and divides by 1, 2 or 4
// assumes the source clock levels are already synchronised to clock_in
`timescale 1ns/1ns
`default_nettype none
module osc_clock_divider (
   // clock and reset
   input  wire       clock_in,
   input  wire       rst_in,
   // source levels
   input  wire       ext_clock_sync_in,
   input  wire       rc_clock_in,
   input  wire       oscillator_source_select_in,
   // divider setting
   input  wire       div2_in,
   input  wire       div4_in,
   // oversampling tick
   output reg        osc_tick_out
);
   reg        src_prev_q;
   reg  [1:0] div_cnt_q;
   wire       src_clk;
   wire       src_rise;
   wire [1:0] div_max;

   assign src_clk  = oscillator_source_select_in ? rc_clock_in : ext_clock_sync_in;
   assign src_rise = src_clk & ~src_prev_q;
   assign div_max  = div4_in ? 2'h3 : (div2_in ? 2'h1 : 2'h0);

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         src_prev_q   <= 1'b0;
         div_cnt_q    <= 2'h0;
         osc_tick_out <= 1'b0;
      end else begin
         src_prev_q   <= src_clk;
         osc_tick_out <= 1'b0;
         if (src_rise) begin
            if (div_cnt_q >= div_max) begin
               div_cnt_q    <= 2'h0;
               osc_tick_out <= 1'b1;
            end else begin
               div_cnt_q <= div_cnt_q + 2'h1;
            end
         end
      end
   end
endmodule
`default_nettype wire

// ==== rtl/sd_adc_core.v ====
// digital core of a single-channel sigma-delta converter with static serial port
// assumes serial pins and the external clock pin are asynchronous to clock_in
`timescale 1ns/1ns
`default_nettype none
`include "sd_adc_defines.vh"
// Overview of operation
// - result is a 16-bit word: 14 magnitude bits, sign and overrange.
// - comparator sampled each oversampling tick into an up/down counter.
// - finished count loads a 16-bit result register at conversion end.
// - oversampling clock is the source divided by one, two or four.
// - select low: oscillator off, source clock taken from the clock pin.
// - select high: oscillator on unless control bit 1 powers it down, driven onto the clock pin as source.
// - shift order sign, overrange, then 14 magnitude bits msb first.
// - overrange set when the magnitude exceeded the reference level.
// - transfers only while chip select low, serial clock up to 2 MHz.
// - output bit changes on falling serial clock, sampled on rising.
// - input bit captured on rising serial clock edge.
// - conversion starts on chip select rise only when valid bit is 1.
// - chip select falling during conversion stops the conversion.
// - a word may be two bytes with any gap, chip select held low.
// - valid bit 1 copies the other 15 bits into the control register.
// - valid bit 0 leaves control unchanged and starts nothing.
// - all registers clear at reset except busy and the chip select synchroniser, which reset high; first transfer shifts out zeros.
// - busy low at conversion start, high at conversion end.
// - serial data output released whenever chip select is high.
module sd_adc_core #(
   parameter BASE_CYCLES = `BASE_CYCLES
) (
   // clock and reset
   input  wire        clock_in,
   input  wire        rst_in,
   // clock source pins
   input  wire        oscillator_source_select_in,
   input  wire        source_clock_pin_in,
   input  wire        rc_osc_in,
   output wire        source_clock_pin_out,
   output wire        source_clock_pin_oe_n_out,
   output wire        rc_osc_enable_out,
   // analog loop
   input  wire        comparator_in,
   input  wire        overrange_detect_in,
   // serial port
   input  wire        chip_select_n_in,
   input  wire        serial_clock_in,
   input  wire        serial_data_in,
   output reg         serial_data_out,
   output wire        serial_data_oe_n_out,
   // status and configuration
   output reg         busy_n_out,
   output reg  [14:0] control_out
);
   // pin order in the synchroniser bank
   localparam PIN_N    = 5;
   localparam PIN_CS   = 0;
   localparam PIN_SCK  = 1;
   localparam PIN_DIN  = 2;
   localparam PIN_SOURCE_CLOCK_PIN = 3;
   localparam PIN_RC   = 4;
   // chip select idles high, so its stages reset high to avoid a false fall
   localparam [4:0] PIN_IDLE = 5'h01;

   // conversion state
   localparam ST_IDLE = 1'b0;
   localparam ST_CONV = 1'b1;

   localparam [19:0] BASE_LEN = BASE_CYCLES[19:0];

   wire [PIN_N-1:0] pin_raw;
   wire [PIN_N-1:0] pin_agree;
   wire [PIN_N-1:0] pin_new;
   wire [PIN_N-1:0] pin_level;

   reg  [15:0] shift_q;
   reg  [15:0] result_q;
   reg  [15:0] count_q;
   reg  [19:0] len_q;
   reg         ovr_q;
   reg         state_q;
   reg         state_d;
   wire        converting;
   wire        osc_tick;
   wire        cs_fall;
   wire        cs_rise;
   wire        sck_rise;
   wire        sck_fall;
   wire        start_conv;
   wire        tick_conv;
   wire        end_conv;
   wire [15:0] count_next;
   wire [19:0] len_next;
   wire [19:0] conv_len;

   assign pin_raw = {rc_osc_in, source_clock_pin_in, serial_data_in,
                     serial_clock_in, chip_select_n_in};

   // three stages per pin; a change counts once stages two and three agree
   genvar g;
   generate
      for (g = 0; g < PIN_N; g = g + 1) begin : pin_sync
         reg [2:0] stage_q;
         reg       level_q;
         always @(posedge clock_in or posedge rst_in) begin
            if (rst_in) begin
               stage_q <= {3{PIN_IDLE[g]}};
               level_q <= PIN_IDLE[g];
            end else begin
               stage_q <= {stage_q[1:0], pin_raw[g]};
               if (stage_q[1] == stage_q[2])
                  level_q <= stage_q[2];
            end
         end
         assign pin_agree[g] = stage_q[1] == stage_q[2];
         assign pin_new[g]   = stage_q[2];
         assign pin_level[g] = level_q;
      end
   endgenerate

   assign cs_fall    = pin_agree[PIN_CS] & ~pin_new[PIN_CS] & pin_level[PIN_CS];
   assign cs_rise    = pin_agree[PIN_CS] & pin_new[PIN_CS] & ~pin_level[PIN_CS];
   assign sck_rise   = pin_agree[PIN_SCK] & pin_new[PIN_SCK] & ~pin_level[PIN_SCK];
   assign sck_fall   = pin_agree[PIN_SCK] & ~pin_new[PIN_SCK] & pin_level[PIN_SCK];
   assign converting = state_q == ST_CONV;
   assign start_conv = cs_rise & shift_q[`VALID_POS];
   assign tick_conv  = converting & osc_tick & ~cs_fall;
   assign count_next = comparator_in ? count_q + 16'h0001 : count_q - 16'h0001;
   assign len_next   = len_q + 20'h0_0001;
   assign end_conv   = tick_conv & (len_next >= conv_len);
   // one base block per step of the conversion field, plus one
   assign conv_len   = BASE_LEN * {16'h0000, control_out[`CONV_MSB:`CONV_LSB]} + BASE_LEN;

   // oscillator runs only when selected and not powered down
   assign rc_osc_enable_out         = oscillator_source_select_in & ~control_out[1];
   assign source_clock_pin_out      = rc_osc_in & rc_osc_enable_out;
   assign source_clock_pin_oe_n_out = ~oscillator_source_select_in;
   assign serial_data_oe_n_out      = pin_level[PIN_CS];

   osc_clock_divider u_div (
      .clock_in                    (clock_in),
      .rst_in                      (rst_in),
      .ext_clock_sync_in           (pin_level[PIN_SOURCE_CLOCK_PIN]),
      .rc_clock_in                 (pin_level[PIN_RC]),
      .oscillator_source_select_in (oscillator_source_select_in),
      .div2_in                     (control_out[`DV2_POS]),
      .div4_in                     (control_out[`DV4_POS]),
      .osc_tick_out                (osc_tick)
   );

   // serial shift register; data is static so any gap between bytes is fine
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         shift_q         <= `RESULT_RESET;
         serial_data_out <= 1'b0;
      end else if (cs_fall) begin
         shift_q         <= result_q;
         serial_data_out <= result_q[15];
      end else if (!pin_level[PIN_CS]) begin
         if (sck_rise && !converting)
            shift_q <= {shift_q[14:0], pin_new[PIN_DIN]};
         if (sck_fall)
            serial_data_out <= shift_q[15];
      end
   end

   // a start always wins; chip select falling aborts a running conversion
   always @* begin
      state_d = state_q;
      case (state_q)
         ST_IDLE: begin
            if (start_conv)
               state_d = ST_CONV;
         end
         ST_CONV: begin
            if (start_conv)
               state_d = ST_CONV;
            else if (cs_fall)
               state_d = ST_IDLE;
            else if (end_conv)
               state_d = ST_IDLE;
         end
         default: state_d = ST_IDLE;
      endcase
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         state_q    <= ST_IDLE;
         busy_n_out <= 1'b1;
      end else begin
         state_q    <= state_d;
         busy_n_out <= state_d != ST_CONV;
      end
   end

   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in)
         control_out <= `CTRL_RESET;
      else if (start_conv)
         control_out <= shift_q[14:0];
   end

   // up/down counter, length count and sticky overrange
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         count_q <= 16'h0000;
         len_q   <= 20'h0_0000;
         ovr_q   <= 1'b0;
      end else if (start_conv) begin
         count_q <= 16'h0000;
         len_q   <= 20'h0_0000;
         ovr_q   <= 1'b0;
      end else if (tick_conv) begin
         count_q <= count_next;
         len_q   <= len_next;
         if (overrange_detect_in)
            ovr_q <= 1'b1;
      end
   end

   // sign, overrange, 14 magnitude bits in twos complement
   always @(posedge clock_in or posedge rst_in) begin
      if (rst_in) begin
         result_q <= `RESULT_RESET;
      end else if (end_conv) begin
         result_q <= {count_next[15], ovr_q | overrange_detect_in,
                      count_next[`MAG_W-1:0]};
      end
   end
endmodule
`default_nettype wire

// ==== rtl/sd_adc_defines.vh ====
// constants for the sigma-delta converter digital core
// assumes inclusion by the core only; its divider module does not include it
`ifndef SD_ADC_DEFINES_VH
`define SD_ADC_DEFINES_VH
`define WORD_W          16
`define MAG_W           14
`define CTRL_W          15
`define VALID_POS       15
`define DV2_POS         7
`define DV4_POS         8
`define CONV_LSB        9
`define CONV_MSB        12
`define CTRL_RESET      15'h0000
`define RESULT_RESET    16'h0000
`define SCLK_MAX_KHZ    2000
`define CLK_MHZ         125
`define SCLK_HALF_CYC   ((`CLK_MHZ * 1000) / (`SCLK_MAX_KHZ * 2))
`define BASE_CYCLES     16'h0400
`endif
